// *** common/corner_pkg.sv ***
// constants and types for the mesh corner auto-switching logic
// What this block does
// - protection latches are set dominant; set beats a simultaneous reset.
// - with external latching, latch outputs simply follow their inputs.
// - without external latching, latched signals hold until intertrip send drops.
// - latched signals feed corner, feeder, transformer and trip reset logic.
// - no sequence starts before protection operated, fault cleared, service permits.
// - reclose lockout wins over reclose start.
// - open disconnector wins over no disconnector operation.
// - required isolation completes before any breaker reclosure.
// - mesh breaker reclosures spaced by a settable interswitch time, nominal 5 s.
// - an inhibited ready breaker passes reclosure to another ready breaker.
// - each plant waits a settable switching delay before isolation starts.
// - isolation starts only with all reclose inhibited and interlocks met.
// - isolation ends on completion or plant operation timer expiry.
// - impossible or failed required isolation locks out reclosure.
// - feeder count 0 to 2 and transformer count 0 to 3 are settings.
// - the corner holds a text label of up to sixteen characters.
// - auto-switch in/out controls set and clear service, with indications.
// - reclose in/out controls enable and disable delayed reclosure.
// - reclose required or not required opens disconnectors; start or lockout.
// - inhibit and lockout inputs act on both mesh and LV reclosure.
// - in-progress indication covers a started sequence until completion.
// - start, inhibit, lockout outputs to mesh and LV; open requests per plant.
// - after power-up the corner starts with auto-switching out of service.
// - in service allows isolation; reclosure waits for reclose-in-service.
package corner_pkg;
   localparam int CLK_HZ = 200000000;
   localparam int TICK_MS = 1;
   // clocks per millisecond tick
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 18;
   localparam int TIME_W = 16;
   localparam int INTERSWITCH_MS = 5000;
   localparam int N_LINES = 2;
   localparam int N_TFMRS = 3;
   localparam int LABEL_CHARS = 16;
   localparam logic [TIME_W-1:0] RST_TIME = 16'h0000;
   typedef enum logic [1:0] {mode_idle, mode_wait, mode_isolate, mode_reclose} seq_t;
endpackage : corner_pkg

// *** rtl/ms_timer.sv ***
// millisecond down-counter driven by the common tick
`timescale 1ns/100ps
module ms_timer
   import corner_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic tick,
   input wire logic load,
   input wire logic [TIME_W-1:0] load_val,
   // status
   output logic expired
);
   logic [TIME_W-1:0] cnt_ff;
   logic [TIME_W-1:0] nxt_cnt;
   // load wins, else count down on each tick, holding at zero
   assign nxt_cnt = load ? load_val :
                    (tick && cnt_ff != RST_TIME) ? cnt_ff - 16'h0001 : cnt_ff;
   // flag from the count only, so load may depend on it without a loop
   assign expired = (cnt_ff == RST_TIME);
   always_ff @(posedge clk) begin
      if (rst) cnt_ff <= RST_TIME;
      else cnt_ff <= nxt_cnt;
   end
endmodule : ms_timer

// *** rtl/corner_logic.sv ***
// mesh corner scheme logic: latches, service state, sequencing
`timescale 1ns/100ps
module corner_logic
   import corner_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // settings
   input wire logic ext_latched,
   input wire logic [1:0] feeder_count,
   input wire logic [1:0] tfmr_count,
   input wire logic [TIME_W-1:0] interswitch_ms,
   input wire logic [TIME_W-1:0] switch_delay_ms,
   input wire logic [TIME_W-1:0] plant_op_ms,
   input wire logic [8*LABEL_CHARS-1:0] label_in,
   input wire logic label_wr,
   // protection inputs (pins)
   input wire logic intertrip_send,
   input wire logic [1:0] line_reclose_req,
   input wire logic [1:0] line_reclose_not_req,
   input wire logic [2:0] tfmr_reclose_not_req,
   input wire logic corner_fault_reclose_required,
   input wire logic corner_fault_reclose_not_required,
   input wire logic breaker_failure,
   input wire logic [1:0] backup_trip,
   input wire logic fault_cleared,
   // control pulses (pins)
   input wire logic auto_in_cmd,
   input wire logic auto_out_cmd,
   input wire logic reclose_in_cmd,
   input wire logic reclose_out_cmd,
   // status inputs (pins)
   input wire logic inhibit_reclose_in,
   input wire logic lockout_reclose_in,
   // plant status from functions
   input wire logic [1:0] line_closed,
   input wire logic [2:0] tfmr_closed,
   input wire logic remote_inhibited,
   input wire logic interlock_ok,
   input wire logic [1:0] cb_ready,
   input wire logic [1:0] cb_inhibited,
   // latched protection outputs
   output logic [1:0] line_reclose_req_lat,
   output logic [1:0] line_reclose_not_req_lat,
   output logic [2:0] tfmr_reclose_not_req_lat,
   output logic corner_req_lat,
   output logic corner_not_req_lat,
   output logic breaker_failure_lat,
   output logic [1:0] backup_trip_lat,
   // indications
   output logic auto_in_service,
   output logic auto_out_of_service,
   output logic reclose_in_service,
   output logic auto_in_progress,
   output logic [8*LABEL_CHARS-1:0] label,
   // reclose outputs
   output logic [1:0] hv_start,
   output logic hv_inhibit,
   output logic hv_lockout,
   output logic lv_start,
   output logic lv_inhibit,
   output logic lv_lockout,
   // isolation requests
   output logic [1:0] open_line_req,
   output logic [2:0] open_tfmr_req
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, change accepted when 2 and 3 agree
   localparam int NSYNC = 21;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
   logic [NSYNC-1:0] nxt_clean;
   assign raw = {intertrip_send, line_reclose_req, line_reclose_not_req, tfmr_reclose_not_req,
                 corner_fault_reclose_required, corner_fault_reclose_not_required,
                 breaker_failure, backup_trip, fault_cleared, auto_in_cmd, auto_out_cmd,
                 reclose_in_cmd, reclose_out_cmd, inhibit_reclose_in, lockout_reclose_in,
                 ext_latched};
   assign nxt_clean = (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         clean_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         clean_ff <= nxt_clean;
      end
   end
   wire c_ext = clean_ff[0];
   wire c_lock = clean_ff[1];
   wire c_inh = clean_ff[2];
   wire c_rout = clean_ff[3];
   wire c_rin = clean_ff[4];
   wire c_aout = clean_ff[5];
   wire c_ain = clean_ff[6];
   wire c_clr = clean_ff[7];
   wire c_its = clean_ff[20];

   ////////////////////////////////////////////////////////////////////////
   // protection latches, set dominant
   // order: line req(2) line notreq(2) tfmr(3) mcf req, mcf notreq, bf, bu(2)
   logic [11:0] set_vec;
   logic [11:0] lat_ff;
   logic [11:0] nxt_lat;
   assign set_vec = {clean_ff[19:18], clean_ff[17:16], clean_ff[15:13], clean_ff[12],
                     clean_ff[11], clean_ff[10], clean_ff[9:8]};
   // external latching: follow input; else hold until intertrip send resets
   assign nxt_lat = c_ext ? set_vec
                          : (set_vec | (lat_ff & {12{c_its}}));
   always_ff @(posedge clk) begin
      if (rst) lat_ff <= '0;
      else lat_ff <= nxt_lat;
   end
   // latched signals leave the block for plant and trip reset logic
   assign line_reclose_req_lat = lat_ff[11:10];
   assign line_reclose_not_req_lat = lat_ff[9:8];
   assign tfmr_reclose_not_req_lat = lat_ff[7:5];
   assign corner_req_lat = lat_ff[4];
   assign corner_not_req_lat = lat_ff[3];
   assign breaker_failure_lat = lat_ff[2];
   assign backup_trip_lat = lat_ff[1:0];

   ////////////////////////////////////////////////////////////////////////
   // service state from rising edges of control pulses
   logic [3:0] ctl_d_ff;
   wire [3:0] ctl_now = {c_ain, c_aout, c_rin, c_rout};
   wire [3:0] ctl_rise = ctl_now & ~ctl_d_ff;
   logic auto_ff, rcl_ff;
   logic nxt_auto, nxt_rcl;
   // out wins over in if both rise together
   assign nxt_auto = ctl_rise[2] ? 1'b0 : (ctl_rise[3] ? 1'b1 : auto_ff);
   assign nxt_rcl = (ctl_rise[0] || !nxt_auto) ? 1'b0 :
                    (ctl_rise[1] ? 1'b1 : rcl_ff);
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_d_ff <= '0;
         auto_ff <= 1'b0;
         rcl_ff <= 1'b0;
      end else begin
         ctl_d_ff <= ctl_now;
         auto_ff <= nxt_auto;
         rcl_ff <= nxt_rcl;
      end
   end
   assign auto_in_service = auto_ff;
   assign auto_out_of_service = !auto_ff;
   assign reclose_in_service = rcl_ff;

   ////////////////////////////////////////////////////////////////////////
   // label and plant count settings
   logic [8*LABEL_CHARS-1:0] label_ff;
   always_ff @(posedge clk) begin
      if (rst) label_ff <= '0;
      else if (label_wr) label_ff <= label_in;
   end
   assign label = label_ff;
   wire [1:0] line_en = {feeder_count >= 2'h2, feeder_count >= 2'h1};
   wire [2:0] tfmr_en = {tfmr_count >= 2'h3, tfmr_count >= 2'h2, tfmr_count >= 2'h1};

   ////////////////////////////////////////////////////////////////////////
   // common millisecond tick
   logic [TICK_W-1:0] tick_cnt_ff;
   wire tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (rst) tick_cnt_ff <= '0;
      else tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // sequence controller
   seq_t st_ff, nxt_st;
   logic fail_ff, nxt_fail;
   logic [1:0] iso_ff, nxt_iso_l;
   logic [2:0] isot_ff, nxt_iso_t;
   logic tmr_load;
   logic [TIME_W-1:0] tmr_val;
   logic tmr_exp;
   ms_timer u_seq_tmr (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .load(tmr_load),
      .load_val(tmr_val),
      .expired(tmr_exp)
   );
   // fault trigger: protection operated and fault cleared
   wire fault_any = corner_req_lat | corner_not_req_lat;
   wire trigger = fault_any && c_clr && auto_ff;
   wire [1:0] line_need = line_closed & line_en;
   wire [2:0] tfmr_need = tfmr_closed & tfmr_en;
   wire need_iso = |line_need || |tfmr_need;
   wire iso_done = !(|(line_closed & iso_ff)) && !(|(tfmr_closed & isot_ff));
   wire c_inh_all = remote_inhibited && (st_ff == mode_isolate);
   wire iso_gate = c_inh_all && interlock_ok;
   // reclose only for required faults, with reclose in service and no failed isolation
   wire want_reclose = corner_req_lat && !corner_not_req_lat && rcl_ff && !fail_ff;

   always_comb begin
      nxt_st = st_ff;
      nxt_fail = fail_ff;
      nxt_iso_l = iso_ff;
      nxt_iso_t = isot_ff;
      tmr_load = 1'b0;
      tmr_val = switch_delay_ms;
      unique case (st_ff)
         mode_idle: begin
            if (trigger) begin
               nxt_fail = 1'b0;
               tmr_load = 1'b1;
               nxt_iso_l = line_need;
               nxt_iso_t = tfmr_need;
               nxt_st = need_iso ? mode_wait : mode_reclose;
            end
         end
         mode_wait: begin
            if (!auto_ff) nxt_st = mode_idle;
            else if (tmr_exp) begin
               tmr_load = 1'b1;
               tmr_val = plant_op_ms;
               nxt_st = mode_isolate;
            end
         end
         mode_isolate: begin
            if (!auto_ff) nxt_st = mode_idle;
            else if (iso_done) nxt_st = mode_reclose;
            else if (tmr_exp) begin
               nxt_fail = 1'b1;
               nxt_st = mode_reclose;
            end
         end
         mode_reclose: begin
            if (!fault_any || !auto_ff) nxt_st = mode_idle;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= mode_idle;
         fail_ff <= 1'b0;
         iso_ff <= '0;
         isot_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         fail_ff <= nxt_fail;
         iso_ff <= nxt_iso_l;
         isot_ff <= nxt_iso_t;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interswitch spacing and breaker selection
   logic [1:0] start_ff, nxt_start;
   logic is_load;
   logic is_exp;
   ms_timer u_is_tmr (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .load(is_load),
      .load_val(interswitch_ms),
      .expired(is_exp)
   );
   wire lockout_all = c_lock || corner_not_req_lat || fail_ff || !rcl_ff;
   wire [1:0] avail = cb_ready & ~cb_inhibited & ~start_ff;
   // first available breaker; inhibited one yields to the next
   wire [1:0] pick = avail[0] ? 2'b01 : (avail[1] ? 2'b10 : 2'b00);
   wire may_start = (st_ff == mode_reclose) && want_reclose && !lockout_all && !c_inh
                    && is_exp;
   assign is_load = may_start && (pick != 2'b00);
   assign nxt_start = (st_ff == mode_reclose && !lockout_all) ? (start_ff | (may_start ?
                      pick : 2'b00)) : 2'b00;
   always_ff @(posedge clk) begin
      if (rst) start_ff <= '0;
      else start_ff <= nxt_start;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs to breakers, LV reclose device and plant functions
   logic [7:0] out_ff;
   wire in_seq = (st_ff == mode_wait) || (st_ff == mode_isolate);
   wire lv_go = (st_ff == mode_reclose) && want_reclose && !lockout_all;
   wire [4:0] open_now = in_seq ? {isot_ff, iso_ff} : 5'h00;
   // lockout input acts at once; a start never stands beside a lockout
   wire hv_lock = c_lock || (lockout_all && fault_any);
   wire hv_free = !lockout_all && !c_lock;
   always_ff @(posedge clk) begin
      if (rst) out_ff <= '0;
      else out_ff <= {st_ff != mode_idle, start_ff & {2{hv_free}}, c_inh || in_seq, hv_lock,
                      lv_go && !c_inh && !c_lock, c_inh || in_seq, hv_lock};
   end
   logic [4:0] open_ff;
   // open requests only once reclosure is inhibited and interlocks met
   always_ff @(posedge clk) begin
      if (rst) open_ff <= '0;
      else open_ff <= iso_gate ? open_now : 5'h00;
   end
   assign auto_in_progress = out_ff[7];
   assign hv_start = out_ff[6:5];
   assign hv_inhibit = out_ff[4];
   assign hv_lockout = out_ff[3];
   assign lv_start = out_ff[2];
   assign lv_inhibit = out_ff[1];
   assign lv_lockout = out_ff[0];
   assign open_line_req = open_ff[1:0];
   assign open_tfmr_req = open_ff[4:2];
endmodule : corner_logic

// *** testbench/corner_logic_checker.sv ***
// concurrent checks on the corner scheme logic ports
`timescale 1ns/100ps
module corner_logic_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched inputs
   input wire logic ext_latched,
   input wire logic intertrip_send,
   input wire logic breaker_failure,
   input wire logic corner_fault_reclose_required,
   input wire logic inhibit_reclose_in,
   input wire logic lockout_reclose_in,
   // watched outputs
   input wire logic breaker_failure_lat,
   input wire logic corner_req_lat,
   input wire logic auto_in_service,
   input wire logic auto_out_of_service,
   input wire logic reclose_in_service,
   input wire logic [1:0] hv_start,
   input wire logic hv_inhibit,
   input wire logic hv_lockout,
   input wire logic lv_start,
   input wire logic lv_inhibit,
   input wire logic lv_lockout
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // latches
   a_latch_set_dom: assert property (breaker_failure [*8] |-> breaker_failure_lat)
      else $error("latch not set by a held input");
   a_hold_until_it: assert property ((!ext_latched && intertrip_send) [*8]
      |-> !$fell(corner_req_lat)) else $error("latch dropped while intertrip high");
   a_follow_ext: assert property ((ext_latched && !corner_fault_reclose_required) [*8]
      |-> !corner_req_lat) else $error("latch not following input");
   ////////////////////////////////////////////////////////////////////////
   // service state and reclose outputs
   a_svc_exclusive: assert property (auto_in_service != auto_out_of_service)
      else $error("service indications disagree");
   a_reclose_needs_svc: assert property ($rose(reclose_in_service) |-> auto_in_service)
      else $error("reclose in service without auto service");
   a_hv_lockout_wins: assert property (hv_lockout |-> hv_start == 2'h0)
      else $error("hv start during lockout");
   a_lv_lockout_wins: assert property (lv_lockout |-> !lv_start)
      else $error("lv start during lockout");
   a_lockout_both: assert property (lockout_reclose_in [*8] |-> hv_lockout && lv_lockout)
      else $error("lockout not on both sides");
   a_inhibit_both: assert property (inhibit_reclose_in [*8] |-> hv_inhibit && lv_inhibit)
      else $error("inhibit not on both sides");
endmodule : corner_logic_checker

bind corner_logic corner_logic_checker checker_inst (.*);

// *** testbench/plant_model.sv ***
// disconnector and breaker functions beside the corner
`timescale 1ns/100ps
module plant_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // requests and pace
   input wire logic [1:0] open_line_req,
   input wire logic [2:0] open_tfmr_req,
   input wire logic slow,
   // plant state
   output logic [1:0] line_closed,
   output logic [2:0] tfmr_closed,
   output logic [1:0] cb_ready,
   output logic remote_inhibited,
   output logic interlock_ok
);
   logic [7:0] run_ff;
   // breakers ready, far end inhibited, interlocks met
   assign cb_ready = 2'h3;
   assign remote_inhibited = 1'b1;
   assign interlock_ok = 1'b1;
   // requested disconnectors open after the motor run time
   always_ff @(posedge clk) begin
      if (rst) begin
         run_ff <= 8'h00;
         line_closed <= 2'h3;
         tfmr_closed <= 3'h7;
      end else if (run_ff == (slow ? 8'hC0 : 8'h08)) begin
         run_ff <= 8'h00;
         line_closed <= line_closed & ~open_line_req;
         tfmr_closed <= tfmr_closed & ~open_tfmr_req;
      end else if (|{open_line_req, open_tfmr_req}) begin
         run_ff <= run_ff + 8'h01;
      end
   end
endmodule : plant_model

// *** testbench/corner_logic_tb.sv ***
// self-checking bench for the corner scheme logic
`timescale 1ns/100ps
module corner_logic_tb
   import corner_pkg::*;
;
   logic clk, rst, ext_latched, label_wr, intertrip_send, fault_cleared, slow;
   logic corner_fault_reclose_required, corner_fault_reclose_not_required, breaker_failure;
   logic auto_in_cmd, auto_out_cmd, reclose_in_cmd, reclose_out_cmd;
   logic inhibit_reclose_in, lockout_reclose_in, remote_inhibited, interlock_ok;
   logic [1:0] feeder_count, tfmr_count, line_reclose_req, line_reclose_not_req, backup_trip;
   logic [1:0] line_closed, cb_ready, cb_inhibited, line_reclose_req_lat, hv_start;
   logic [1:0] line_reclose_not_req_lat, backup_trip_lat, open_line_req;
   logic [2:0] tfmr_reclose_not_req, tfmr_closed, tfmr_reclose_not_req_lat, open_tfmr_req;
   logic [TIME_W-1:0] interswitch_ms, switch_delay_ms, plant_op_ms;
   logic [8*LABEL_CHARS-1:0] label_in, label;
   logic corner_req_lat, corner_not_req_lat, breaker_failure_lat, auto_in_service;
   logic auto_out_of_service, reclose_in_service, auto_in_progress, hv_inhibit, hv_lockout;
   logic lv_start, lv_inhibit, lv_lockout;
   logic [3:0] cmd;
   logic [1:0] prot;
   typedef struct {string name; bit lbl; logic [127:0] mask; logic [127:0] exp; int due;} note_t;
   note_t notes[$];
   note_t n;
   int seed = 32'h9d8c;
   int cyc = 0;
   int mismatches, num_checks;
   wire [127:0] stat = {107'h0, line_closed, tfmr_closed, open_line_req, open_tfmr_req,
      |hv_start, auto_in_progress, auto_in_service,
      auto_out_of_service, reclose_in_service, breaker_failure_lat, corner_req_lat,
      hv_lockout, lv_lockout, hv_inhibit, lv_inhibit};
   assign {auto_in_cmd, auto_out_cmd, reclose_in_cmd, reclose_out_cmd} = cmd;
   assign {breaker_failure, corner_fault_reclose_required} = prot;

   corner_logic dut (.*);
   plant_model model (.*);
   ////////////////////////////////////////////////////////////////////////
   // tasks
   task automatic step(input int k);
      repeat (k) @(posedge clk);
   endtask : step
   task automatic note(input string name, input bit lbl, input logic [127:0] mask, exp);
      notes.push_back('{name, lbl, mask, exp, cyc + 2});
   endtask : note
   task automatic check(input string name, input logic [127:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // a control pulse stands for the two second command
   task automatic pulse(input logic [3:0] which);
      cmd <= which;
      step(20);
      cmd <= 4'h0;
      step(20);
   endtask : pulse
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////
   // clock, cycle count and hang limit
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         mismatches++;
         finish_test();
      end
   end
   // compare each due note with the watched outputs
   always @(negedge clk) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         n = notes.pop_front();
         check(n.name, n.lbl ? label : stat & n.mask, n.exp);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // stimulus
   initial begin
      {rst, cmd, prot} = {1'b1, 4'h0, 2'h0};
      {ext_latched, label_wr, intertrip_send, fault_cleared, slow} = 5'h0;
      {corner_fault_reclose_not_required, inhibit_reclose_in, lockout_reclose_in} = 3'h0;
      {line_reclose_req, line_reclose_not_req, backup_trip, cb_inhibited} = 8'h00;
      {tfmr_reclose_not_req, feeder_count, tfmr_count} = {3'h0, 2'h2, 2'h3};
      {interswitch_ms, switch_delay_ms, plant_op_ms} = {16'h0000, 16'h0000, 16'h0001};
      label_in = '0;
      step(20);
      rst <= 1'b0;
      step(2);
      note("reset state", 0, 128'h7FF, 128'h080);
      label_in <= {$random(seed), $random(seed), $random(seed), $random(seed)};
      label_wr <= 1'b1;
      step(1);
      label_wr <= 1'b0;
      step(4);
      note("label", 1, 128'h0, label_in);
      $display("test reset and label done");
      // service controls, refused orders included
      pulse(4'h2);
      note("reclose refused", 0, 128'h1C0, 128'h080);
      pulse(4'h8);
      note("auto in", 0, 128'h1C0, 128'h100);
      pulse(4'h2);
      note("reclose in", 0, 128'h1C0, 128'h140);
      pulse(4'h1);
      note("reclose out", 0, 128'h1C0, 128'h100);
      pulse(4'hC);
      note("auto out wins", 0, 128'h1C0, 128'h080);
      $display("test service done");
      // internal latching, then set against reset, then external latching
      intertrip_send <= 1'b1;
      prot <= 2'h3;
      step(10);
      prot <= 2'h0;
      step(20);
      note("held latch", 0, 128'h630, 128'h030);
      intertrip_send <= 1'b0;
      step(20);
      note("latch reset", 0, 128'h030, 128'h000);
      prot <= 2'h3;
      step(20);
      note("set dominant", 0, 128'h030, 128'h030);
      {prot, ext_latched, intertrip_send} <= 4'h3;
      step(20);
      note("ext follow", 0, 128'h030, 128'h000);
      $display("test latches done");
      // inhibit then lockout on both reclose sides
      inhibit_reclose_in <= 1'b1;
      step(20);
      note("inhibit", 0, 128'h003, 128'h003);
      {inhibit_reclose_in, lockout_reclose_in} <= 2'h1;
      step(20);
      note("lockout", 0, 128'h00C, 128'h00C);
      lockout_reclose_in <= 1'b0;
      // corner fault needing no reclosure while in service
      cb_inhibited <= 2'($random(seed));
      slow <= 1'($random(seed));
      pulse(4'h8);
      pulse(4'h2);
      {fault_cleared, corner_fault_reclose_not_required} <= 2'h3;
      step(100);
      note("fault lockout", 0, 128'h00C, 128'h00C);
      step(300);
      note("isolated", 0, 128'h1FFA00, 128'h000200);
      step(20);
      $display("test corner fault done");
      finish_test();
   end
endmodule : corner_logic_tb
